// ===== design/eec_config_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "eec_params.svh"

module eec_config_control #(
   parameter int ADDR_W      = 8,
   parameter int WORDS       = `EEC_WORDS,
   parameter int HALF_CYCLES = `EEC_HALF_CYCLES
) (
   // Clock and reset.
   input  wire logic                     clk,
   input  wire logic                     reset,
   // Register port.
   input  wire logic [ADDR_W-1:0]        regAddr,
   input  wire logic [15:0]              regWrData,
   input  wire logic                     regWrite,
   input  wire logic                     regRead,
   output logic      [15:0]              regRdData,
   // External data port, low three bits: shift clock, data in, data out.
   input  wire logic [2:0]               extDataIn,
   output logic      [2:0]               extDataOut,
   output logic      [2:0]               extDataOe,
   // Serial memory chip select.
   output logic                          romChipSelect,
   // Shift-busy pin.
   input  wire logic                     shiftBusyIn,
   output logic                          shiftBusyOut,
   output logic                          shiftBusyOe,
   // Load status and loaded configuration words.
   output logic                          loadBusy,
   input  wire logic [$clog2(WORDS)-1:0] cfgAddr,
   output logic      [15:0]              cfgData
);

   localparam int TOTAL_BITS = `EEC_CMD_BITS + 16 * WORDS;
   localparam int WAW        = $clog2(WORDS);

   eec_pkg::eec_state_t state_reg, state_next;
   eec_pkg::eec_ctrl_t  ctrl_reg, ctrl_next;
   eec_pkg::eec_pins_t  pins_reg, pins_next;
   logic [1:0]          syncA_reg, syncB_reg;
   logic [15:0]         halfCnt_reg;
   logic [15:0]         bitCnt_reg;
   logic [3:0]          probeCnt_reg;
   logic                phase_reg;
   logic [15:0]         shiftWord_reg;
   logic [7:0]          sum_reg;
   logic [WAW-1:0]      wordIdx_reg;
   logic                present_reg;
   logic                valid_reg;
   logic                loadCmd_reg;
   logic [15:0]         rdData_reg;
   logic                loadBusy_reg;
   logic                wrAccept, rdAccept, startLoad;
   logic                bitDone, wordDone, lastBit;
   logic                loadDi, syncDo, syncSb;
   logic [15:0]         dataIdx;
   logic [15:0]         wordNow;

   // Address decode shared by the read and write paths.
   function automatic logic regHit(input logic [ADDR_W-1:0] addr);
      regHit = (addr == ADDR_W'(`EEC_REG_OFFSET));
   endfunction

   // Accesses only count while no load runs.
   assign wrAccept  = regWrite && regHit(regAddr) && (state_reg == eec_pkg::EEC_IDLE);
   assign rdAccept  = regRead && regHit(regAddr) && (state_reg == eec_pkg::EEC_IDLE);
   assign startLoad = wrAccept && regWrData[`EEC_LOAD_BIT];
   assign syncDo    = syncB_reg[0];
   assign syncSb    = syncB_reg[1];

   // Two-stage synchronisers for the memory data output and shift-busy pin.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         syncA_reg <= 2'h0;
         syncB_reg <= 2'h0;
      end else begin
         syncA_reg <= {shiftBusyIn, extDataIn[2]};
         syncB_reg <= syncA_reg;
      end
   end

   // Software control bits; reserved bits are dropped on write.
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wrAccept) begin
         ctrl_next = eec_pkg::eec_ctrl_t'(regWrData[`EEC_ENABLE_BIT:0]);
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_reg <= eec_pkg::eec_ctrl_t'(`EEC_CTRL_RESET);
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // Serial bit timing during the automatic load.
   assign bitDone  = (state_reg == eec_pkg::EEC_SHIFT) && phase_reg &&
                     (halfCnt_reg == 16'(HALF_CYCLES - 1));
   assign lastBit  = (bitCnt_reg == 16'(TOTAL_BITS - 1));
   assign dataIdx  = bitCnt_reg - 16'(`EEC_CMD_BITS);
   assign wordDone = bitDone && (bitCnt_reg >= 16'(`EEC_CMD_BITS)) && (dataIdx[3:0] == 4'hf);
   assign wordNow  = {shiftWord_reg[14:0], syncDo};
   assign loadDi   = (bitCnt_reg < 16'(`EEC_CMD_BITS)) ?
                     1'(`EEC_READ_CMD >> (4'(`EEC_CMD_BITS - 1) - bitCnt_reg[3:0])) : 1'b0;

   // Load sequencer next state.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         eec_pkg::EEC_IDLE: begin
            if (startLoad) begin
               state_next = eec_pkg::EEC_PROBE;
            end
         end
         eec_pkg::EEC_PROBE: begin
            if (probeCnt_reg == 4'(`EEC_PROBE_CYCLES - 1)) begin
               state_next = syncSb ? eec_pkg::EEC_SHIFT : eec_pkg::EEC_DONE;
            end
         end
         eec_pkg::EEC_SHIFT: begin
            if (bitDone && lastBit) begin
               state_next = eec_pkg::EEC_DONE;
            end
         end
         eec_pkg::EEC_DONE: begin
            state_next = eec_pkg::EEC_IDLE;
         end
         default: begin
            state_next = eec_pkg::EEC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg    <= eec_pkg::EEC_IDLE;
         loadBusy_reg <= 1'b0;
      end else begin
         state_reg    <= state_next;
         loadBusy_reg <= (state_next != eec_pkg::EEC_IDLE);
      end
   end

   // Probe window: the shift-busy pin is released and then sampled.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         probeCnt_reg <= 4'h0;
         present_reg  <= 1'b0;
      end else if (state_reg == eec_pkg::EEC_PROBE) begin
         probeCnt_reg <= probeCnt_reg + 4'h1;
         present_reg  <= syncSb;
      end else begin
         probeCnt_reg <= 4'h0;
      end
   end

   // Half-period counter and generated shift clock level.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         halfCnt_reg <= 16'h0;
         phase_reg   <= 1'b0;
      end else if (state_reg != eec_pkg::EEC_SHIFT) begin
         halfCnt_reg <= 16'h0;
         phase_reg   <= 1'b0;
      end else if (halfCnt_reg == 16'(HALF_CYCLES - 1)) begin
         halfCnt_reg <= 16'h0;
         phase_reg   <= ~phase_reg;
      end else begin
         halfCnt_reg <= halfCnt_reg + 16'h1;
      end
   end

   // Bit counter and word shifter; data is taken at the end of the high phase.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bitCnt_reg    <= 16'h0;
         shiftWord_reg <= 16'h0;
         wordIdx_reg   <= '0;
      end else if (state_reg == eec_pkg::EEC_PROBE) begin
         bitCnt_reg  <= 16'h0;
         wordIdx_reg <= '0;
      end else if (bitDone) begin
         bitCnt_reg    <= bitCnt_reg + 16'h1;
         shiftWord_reg <= wordNow;
         if (wordDone) begin
            wordIdx_reg <= wordIdx_reg + WAW'(1);
         end
      end
   end

   // Checksum over both bytes of every captured word, modulo 256.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sum_reg <= 8'h00;
      end else if (startLoad) begin
         sum_reg <= 8'h00;
      end else if (wordDone) begin
         sum_reg <= sum_reg + wordNow[15:8] + wordNow[7:0];
      end
   end

   // Valid flag is cleared at start and settled when the load completes.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         valid_reg <= 1'b0;
      end else if (startLoad) begin
         valid_reg <= 1'b0;
      end else if (state_reg == eec_pkg::EEC_DONE) begin
         valid_reg <= present_reg && (sum_reg == `EEC_CKSUM_GOOD);
      end
   end

   // Load command bit stands until the sequencer finishes.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         loadCmd_reg <= 1'b0;
      end else if (startLoad) begin
         loadCmd_reg <= 1'b1;
      end else if (state_reg == eec_pkg::EEC_DONE) begin
         loadCmd_reg <= 1'b0;
      end
   end

   // Pin drive: load sequencer, direct access, or released port.
   always_comb begin
      pins_next         = pins_reg;
      pins_next.sbOe    = 1'b1;
      if (state_next != eec_pkg::EEC_IDLE) begin
         pins_next.chipSel = (state_reg == eec_pkg::EEC_SHIFT);
         pins_next.extOut  = {1'b0, loadDi, phase_reg};
         pins_next.extOe   = 3'h3;
         pins_next.sbOe    = 1'b0;
      end else if (ctrl_next.enable) begin
         pins_next.chipSel = ctrl_next.chipSel;
         pins_next.extOut  = {1'b0, ctrl_next.dataIn, ctrl_next.shiftClk};
         pins_next.extOe   = 3'h3;
         pins_next.sbOut   = ctrl_next.shiftBusy;
      end else begin
         pins_next.chipSel = 1'b0;
         pins_next.extOut  = 3'h0;
         pins_next.extOe   = 3'h0;
      end
   end

   // The shift-busy level is held in sbOut whenever direct access is off.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pins_reg <= '0;
      end else begin
         pins_reg <= pins_next;
      end
   end

   // Register read, answered in the next cycle; reserved bits read zero.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdData_reg <= 16'h0;
      end else if (rdAccept) begin
         rdData_reg <= {valid_reg, loadCmd_reg, 9'h000, ctrl_reg.enable, ctrl_reg.shiftBusy,
                        ctrl_reg.chipSel, ctrl_reg.shiftClk, syncDo};
      end else begin
         rdData_reg <= 16'h0;
      end
   end

   // Storage of the loaded configuration words.
   eec_cfg_mem #(
      .WIDTH (16),
      .DEPTH (WORDS)
   ) u_mem (
      .clk    (clk),
      .reset  (reset),
      .wrEn   (wordDone),
      .wrAddr (wordIdx_reg),
      .wrData (wordNow),
      .rdAddr (cfgAddr),
      .rdData (cfgData)
   );

   // Outputs straight from flip-flops.
   assign regRdData     = rdData_reg;
   assign extDataOut    = pins_reg.extOut;
   assign extDataOe     = pins_reg.extOe;
   assign romChipSelect = pins_reg.chipSel;
   assign shiftBusyOut  = pins_reg.sbOut;
   assign shiftBusyOe   = pins_reg.sbOe;
   assign loadBusy      = loadBusy_reg;

   // Cycle count of the shift phase of one load, only read by the checks below.
   logic [23:0] loadCycles_reg;
   localparam int SHIFT_CYCLES = 2 * HALF_CYCLES * TOTAL_BITS;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         loadCycles_reg <= 24'h0;
      end else if (state_reg == eec_pkg::EEC_SHIFT) begin
         loadCycles_reg <= loadCycles_reg + 24'h1;
      end else if (state_reg == eec_pkg::EEC_IDLE) begin
         loadCycles_reg <= 24'h0;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   valid_at_end_a: assert property (
      state_reg == eec_pkg::EEC_DONE |=> valid_reg == $past(present_reg &&
                                                            sum_reg == 8'hff))
      else $error("valid flag does not match checksum at end of load");
   absent_invalid_a: assert property (
      state_reg == eec_pkg::EEC_PROBE && state_next == eec_pkg::EEC_DONE |=> ##1 !valid_reg)
      else $error("valid flag set with no memory present");
   load_start_a: assert property (
      startLoad |=> state_reg == eec_pkg::EEC_PROBE && loadCmd_reg && loadBusy)
      else $error("load did not start on command write");
   ignore_bus_a: assert property (
      state_reg != eec_pkg::EEC_IDLE |=> $stable(ctrl_reg) && regRdData == 16'h0)
      else $error("bus access acted on during load");
   load_clear_a: assert property (
      state_reg == eec_pkg::EEC_DONE |=> !loadCmd_reg && !loadBusy)
      else $error("load command bit not cleared after load");
   load_time_a: assert property (
      state_reg == eec_pkg::EEC_SHIFT && state_next == eec_pkg::EEC_DONE
      |-> loadCycles_reg == 24'(SHIFT_CYCLES - 1))
      else $error("serial load length wrong");
   idle_release_a: assert property (
      !ctrl_reg.enable && !loadBusy |-> extDataOe == 3'h0 && !romChipSelect)
      else $error("pins driven while direct access is off");
   sb_hold_a: assert property (
      !ctrl_next.enable && state_next == eec_pkg::EEC_IDLE |=> $stable(shiftBusyOut))
      else $error("shift-busy pin changed while direct access is off");
   direct_follow_a: assert property (
      wrAccept && regWrData[4] && !regWrData[14] |=> romChipSelect == $past(regWrData[2]) &&
      extDataOut[1:0] == $past({regWrData[0], regWrData[1]}) &&
      shiftBusyOut == $past(regWrData[3]))
      else $error("pins did not follow a direct access write");
   resv_zero_a: assert property (
      regRdData[13:5] == 9'h000)
      else $error("reserved bits read non-zero");

   load_seen_c: cover property (startLoad ##1 state_reg == eec_pkg::EEC_PROBE);
   load_good_c: cover property (state_reg == eec_pkg::EEC_DONE ##1 valid_reg);
   absent_c: cover property (state_reg == eec_pkg::EEC_PROBE && state_next == eec_pkg::EEC_DONE);
   direct_c: cover property (wrAccept && regWrData[4] ##1 extDataOe == 3'h3);

endmodule
`default_nettype wire

// ===== inc/eec_params.svh
`ifndef EEC_PARAMS_SVH
`define EEC_PARAMS_SVH

// Register placement and field positions of the configuration register.
`define EEC_REG_OFFSET    8'h00
`define EEC_VALID_BIT     15
`define EEC_LOAD_BIT      14
`define EEC_RESV_HI       13
`define EEC_RESV_LO       5
`define EEC_ENABLE_BIT    4
`define EEC_SBUSY_BIT     3
`define EEC_CS_BIT        2
`define EEC_SCLK_BIT      1
`define EEC_DATA_BIT      0

// Control reset value and good checksum value.
`define EEC_CTRL_RESET    5'h00
`define EEC_CKSUM_GOOD    8'hff

// Serial read command: start bit, read opcode, word address zero.
`define EEC_READ_CMD      9'h180
`define EEC_CMD_BITS      9
`define EEC_WORDS         64

// Timing: whole load time and system clock period, both in ns.
`define EEC_LOAD_TIME_NS  1400000
`define EEC_CLK_PERIOD_NS 4
`define EEC_PROBE_CYCLES  8
`define EEC_HALF_CYCLES   (`EEC_LOAD_TIME_NS / (2 * `EEC_CLK_PERIOD_NS * \
                           (`EEC_CMD_BITS + 16 * `EEC_WORDS)))

`endif

// ===== inc/eec_pkg.sv
package eec_pkg;

   // Load sequencer states, Gray coded along idle, probe, shift, done.
   typedef enum logic [2:0] {
      EEC_IDLE  = 3'h0,
      EEC_PROBE = 3'h1,
      EEC_SHIFT = 3'h3,
      EEC_DONE  = 3'h2
   } eec_state_t;

   // Software controlled bits 4 down to 0 of the configuration register.
   typedef struct packed {
      logic enable;
      logic shiftBusy;
      logic chipSel;
      logic shiftClk;
      logic dataIn;
   } eec_ctrl_t;

   // Everything the block drives toward the serial memory.
   typedef struct packed {
      logic       chipSel;
      logic [2:0] extOut;
      logic [2:0] extOe;
      logic       sbOut;
      logic       sbOe;
   } eec_pins_t;

endpackage

// ===== design/eec_cfg_mem.sv
`timescale 1ns/100ps
`default_nettype none

// Holds the configuration words captured by the automatic load.
module eec_cfg_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 64,
   parameter int AW    = $clog2(DEPTH)
) (
   // Clock and reset.
   input  wire logic             clk,
   input  wire logic             reset,
   // Write port.
   input  wire logic             wrEn,
   input  wire logic [AW-1:0]    wrAddr,
   input  wire logic [WIDTH-1:0] wrData,
   // Read port, data one cycle after the address.
   input  wire logic [AW-1:0]    rdAddr,
   output logic      [WIDTH-1:0] rdData
);

   logic [WIDTH-1:0] mem [DEPTH];

   // Array write; the array itself carries no reset.
   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // Registered read data.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdData <= '0;
      end else begin
         rdData <= mem[rdAddr];
      end
   end

endmodule
`default_nettype wire

// ===== tb/eec_rom_model.sv
`timescale 1ns/100ps
`default_nettype none

// Behavioural serial memory: takes a 9-bit command, then streams its image msb first.
module eec_rom_model #(
   parameter int WORDS = 2
) (
   // Serial lines from the block.
   input  wire logic                 chipSel,
   input  wire logic                 shiftClk,
   input  wire logic                 dataIn,
   output logic                      dataOut,
   // Stored image, word i at bits 16*i+15 down to 16*i, and presence strap.
   input  wire logic [16*WORDS-1:0]  image,
   input  wire logic                 present
);
   int         bitCnt = 0;
   int         outIdx = 0;
   logic [8:0] cmdReg = 9'h000;

   initial dataOut = 1'b0;

   // Command bits are taken on rising shift clock edges while selected.
   always @(posedge shiftClk) begin
      if (chipSel && present && bitCnt < 9) begin
         cmdReg = {cmdReg[7:0], dataIn};
         bitCnt++;
      end
   end

   // Data bits change on falling edges, so they are settled long before sampling.
   always @(negedge shiftClk) begin
      if (chipSel && present && bitCnt >= 9 && cmdReg == 9'h180) begin
         dataOut = image[16 * (outIdx / 16) + 15 - (outIdx % 16)];
         outIdx = (outIdx + 1) % (16 * WORDS);
      end
   end

   // Deselect ends the frame; the released line shows the inverse of its last level.
   always @(negedge chipSel) begin
      bitCnt = 0;
      outIdx = 0;
      dataOut = ~dataOut;
   end
endmodule

`default_nettype wire

// ===== tb/test_eec_config_control.sv
`timescale 1ns/100ps
`default_nettype none

module test_eec_config_control;
   localparam int WORDS = 2;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [7:0]  regAddr = 8'h00;
   logic [15:0] regWrData = 16'h0000;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic [15:0] regRdData;
   logic [2:0]  extDataOut;
   logic [2:0]  extDataOe;
   logic        romChipSelect;
   logic        shiftBusyOut;
   logic        shiftBusyOe;
   logic        loadBusy;
   logic        romDo;
   logic        present = 1'b1;
   logic [0:0]  cfgAddr = 1'b0;
   logic [15:0] cfgData;
   logic [31:0] image = 32'h5663_1234;
   int          errorCnt = 0;
   int          checkCount = 0;
   logic [15:0] rv;
   int          n;

   // Port lines fall to zero where nobody drives; shift-busy is pulled up by a fitted memory.
   wire logic [2:0]  portLine = extDataOut & extDataOe;
   wire logic        shiftBusyPin = shiftBusyOe ? shiftBusyOut : present;
   wire logic [15:0] pinVec = {7'h00, romChipSelect, extDataOut, extDataOe,
                               shiftBusyOut, shiftBusyOe};

   always #2 clk = ~clk;

   eec_config_control #(.ADDR_W(8), .WORDS(WORDS), .HALF_CYCLES(6)) uut (
      .clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .extDataIn({romDo, portLine[1:0]}), .extDataOut(extDataOut), .extDataOe(extDataOe),
      .romChipSelect(romChipSelect), .shiftBusyIn(shiftBusyPin),
      .shiftBusyOut(shiftBusyOut), .shiftBusyOe(shiftBusyOe), .loadBusy(loadBusy),
      .cfgAddr(cfgAddr), .cfgData(cfgData));

   eec_rom_model #(.WORDS(WORDS)) rom (
      .chipSel(romChipSelect), .shiftClk(portLine[0]), .dataIn(portLine[1]),
      .dataOut(romDo), .image(image), .present(present));

   // Prints the counts and the verdict, then stops.
   task automatic completeRun();
      $display("checks %0d mismatches %0d", checkCount, errorCnt);
      if (errorCnt == 0 && checkCount > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Compares the bits selected by the mask.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] mask);
      checkCount++;
      if ((got & mask) !== (exp & mask)) begin
         errorCnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One-cycle write strobe; returns just after the edge that takes it.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      #1;
   endtask

   // One-cycle read strobe; data is taken in the following cycle.
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 d = regRdData;
   endtask

   task automatic idle(input int k);
      repeat (k) @(posedge clk);
   endtask

   // Main sequence.
   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      idle(2);
      rd(8'h00, rv);
      chk(rv, 16'h0000, 16'hfffe);
      chk(pinVec, 16'h0001, 16'hffff);
      $display("reset test done");
      wr(8'h00, 16'h001d);
      chk(pinVec, 16'h014f, 16'hffff);
      rd(8'h00, rv);
      chk(rv, 16'h001d, 16'hfffe);
      wr(8'h00, 16'h001f);
      chk(pinVec, 16'h016f, 16'hffff);
      rd(8'h00, rv);
      chk(rv, 16'h001f, 16'hfffe);
      wr(8'h04, 16'h0000);
      rd(8'h00, rv);
      chk(rv, 16'h001f, 16'hfffe);
      rd(8'h04, rv);
      chk(rv, 16'h0000, 16'hffff);
      $display("register test done");
      // Deselect first so the memory starts a fresh frame for the read command.
      wr(8'h00, 16'h0018);
      for (int i = 8; i >= 0; i--) begin
         wr(8'h00, 16'h001c | 16'((9'h180 >> i) & 9'h001));
         idle(4);
         wr(8'h00, 16'h001e | 16'((9'h180 >> i) & 9'h001));
         idle(4);
      end
      for (int k = 0; k < 16; k++) begin
         wr(8'h00, 16'h001c);
         idle(4);
         rd(8'h00, rv);
         chk(rv, 16'h001c | {15'h0000, image[15 - k]}, 16'hffff);
         wr(8'h00, 16'h001e);
         idle(4);
      end
      $display("direct access test done");
      wr(8'h00, 16'h0014);
      chk(pinVec, 16'h010d, 16'hffff);
      wr(8'h00, 16'h0008);
      chk(pinVec, 16'h0001, 16'hffff);
      $display("enable test done");
      // Good image, bad checksum, and no memory fitted.
      for (int c = 0; c < 3; c++) begin
         image <= (c == 1) ? 32'h5664_1234 : 32'h5663_1234;
         present <= (c != 2);
         wr(8'h00, 16'h4000);
         chk({15'h0000, loadBusy & ~shiftBusyOe}, 16'h0001, 16'hffff);
         // Another register is written, so the load write stays the last one here.
         wr(8'h04, 16'h001d);
         rd(8'h00, rv);
         chk(rv, 16'h0000, 16'hffff);
         chk(pinVec & 16'h0100, 16'h0000, 16'hffff);
         n = 5;
         while (loadBusy === 1'b1 && n < 2000) begin
            @(posedge clk);
            #1 n++;
         end
         if (n >= 2000) begin
            errorCnt++;
            completeRun();
         end
         chk({15'h0000, (c == 2) ? (n >= 8 && n <= 14) : (n >= 498 && n <= 506)},
             16'h0001, 16'hffff);
         rd(8'h00, rv);
         chk(rv, {c == 0, 15'h0000}, 16'hfffe);
         for (int w = 0; w < WORDS && c == 0; w++) begin
            @(posedge clk);
            cfgAddr <= 1'(w);
            idle(2);
            #1 chk(cfgData, image[16 * w +: 16], 16'hffff);
         end
         $display("load test %0d done", c);
      end
      completeRun();
   end
endmodule

`default_nettype wire
